/* uart_break_pkg.sv */
// Constants and types for the baud and break control block
package uart_break_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] CLKSEL_OFFSET = 8'h04;
    localparam logic [7:0] DIVISOR_OFFSET = 8'h08;
    localparam logic [7:0] CONTROL_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam logic [7:0] MASK_OFFSET = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POWER_POS = 7;
    localparam int TX_ENABLE_POS = 6;
    localparam int RX_ENABLE_POS = 5;
    localparam int TRIGGER_POS = 6;
    localparam int FAIL_FLAG_POS = 0;
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EVENT_COUNT = 2;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [3:0] PRESCALE_RESET = 4'h0;
    localparam logic [7:0] DIVISOR_RESET = 8'hff;
    localparam logic [3:0] PRESCALE_MAX = 4'ha;
    localparam logic [4:0] BREAK_MIN_BITS = 5'h0b;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic power;
        logic txEnable;
        logic rxEnable;
    } mode_type;

    typedef struct packed {
        logic active;
        logic write;
        logic [7:0] addr;
    } bus_phase_type;

endpackage : uart_break_pkg

/* uart_baud_gen.sv */
// Prescaler, 8-bit divisor counter and halving stage for the baud clock
`timescale 1ns/1ns
module uart_baud_gen
    import uart_break_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [3:0] prescale,
    input wire logic [7:0] divisor,
    output logic baudClk,
    output logic bitTick
);
    logic [10:0] preCount;
    logic [10:0] next_preCount;
    logic [7:0] divCount;
    logic [7:0] next_divCount;
    logic divPulse;
    logic next_divPulse;
    logic next_baudClk;
    logic next_bitTick;
    logic preTick;

    // Prescale tick every 2^prescale clocks (every 2^10 above 10), divisor pulse every divisor ticks
    always_comb begin
        logic [10:0] preLimit;
        preLimit = 11'h000;
        if (prescale > PRESCALE_MAX) begin
            preLimit = 11'h3ff;
        end else begin
            preLimit = 11'((11'h001 << prescale) - 11'h001);
        end
        preTick = run && (preCount == preLimit);
        next_preCount = (!run || preTick) ? 11'h000 : 11'(preCount + 11'h001);
        next_divPulse = 1'b0;
        next_divCount = divCount;
        if (!run) begin
            next_divCount = 8'h00;
        end else if (preTick) begin
            if (divCount >= divisor - 8'h01 || divisor == 8'h00) begin
                next_divCount = 8'h00;
                next_divPulse = 1'b1;
            end else begin
                next_divCount = 8'(divCount + 8'h01);
            end
        end
        // Halving stage: one toggle per counter output pulse
        next_baudClk = !run ? 1'b0 : (divPulse ? !baudClk : baudClk);
        next_bitTick = run && divPulse && !baudClk;
    end

    // Registers of the divider chain
    always_ff @(posedge clk) begin
        if (rst) begin
            preCount <= 11'h000;
            divCount <= 8'h00;
            divPulse <= 1'b0;
            baudClk <= 1'b0;
            bitTick <= 1'b0;
        end else begin
            preCount <= next_preCount;
            divCount <= next_divCount;
            divPulse <= next_divPulse;
            baudClk <= next_baudClk;
            bitTick <= next_bitTick;
        end
    end

    a_baud_halving: assert property (@(posedge clk) disable iff (rst)
        (run && $past(run) && $changed(baudClk)) |-> $past(divPulse))
        else $error("baud clock moved without a divisor pulse");

endmodule : uart_baud_gen

/* uart_break_detect.sv */
// Sync-break field detector counting low bit times on the receive line
`timescale 1ns/1ns
module uart_break_detect
    import uart_break_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic enable,
    input wire logic bitTick,
    input wire logic rxd,
    output logic done,
    output logic ok
);
    typedef enum {IDLE, WAIT_LOW, COUNT_LOW} det_state_type;
    det_state_type state;
    det_state_type next_state;
    logic [4:0] lowBits;
    logic [4:0] next_lowBits;
    logic next_done;
    logic next_ok;

    // Wait for the line to fall, count low bit times, judge on the rise
    always_comb begin
        next_state = state;
        next_lowBits = lowBits;
        next_done = 1'b0;
        next_ok = 1'b0;
        case (state)
            IDLE: begin
                if (start && enable) begin
                    next_state = WAIT_LOW;
                end
            end
            WAIT_LOW: begin
                next_lowBits = 5'h00;
                if (!rxd) begin
                    next_state = COUNT_LOW;
                end
            end
            COUNT_LOW: begin
                if (rxd) begin
                    next_state = IDLE;
                    next_done = 1'b1;
                    next_ok = lowBits >= BREAK_MIN_BITS;
                end else if (bitTick && lowBits != 5'h1f) begin
                    next_lowBits = 5'(lowBits + 5'h01);
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
        // A fresh start re-arms; loss of enable aborts silently unless the line rises in the same cycle
        if (!enable) begin
            next_state = IDLE;
        end else if (start) begin
            next_state = WAIT_LOW;
            next_done = 1'b0;
            next_ok = 1'b0;
        end
    end

    // Detector registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDLE;
            lowBits <= 5'h00;
            done <= 1'b0;
            ok <= 1'b0;
        end else begin
            state <= next_state;
            lowBits <= next_lowBits;
            done <= next_done;
            ok <= next_ok;
        end
    end

    a_break_length: assert property (@(posedge clk) disable iff (rst)
        ok |-> done && $past(lowBits) >= BREAK_MIN_BITS)
        else $error("break accepted while too short");

endmodule : uart_break_detect

/* uart_baud_and_break_control.sv */
// Top: AHB-Lite registers, baud generation and break reception control
`timescale 1ns/1ns
module uart_baud_and_break_control
    import uart_break_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd,
    output logic baudClk,
    output logic breakActive,
    output logic irq
);
    // ************************************************************
    // State
    // ************************************************************
    bus_phase_type dataPhase;
    bus_phase_type next_dataPhase;
    logic [31:0] next_hrdata;
    mode_type mode;
    mode_type next_mode;
    logic [3:0] prescale;
    logic [3:0] next_prescale;
    logic [7:0] divisor;
    logic [7:0] next_divisor;
    logic failFlag;
    logic next_failFlag;
    logic next_breakActive;
    logic [EVENT_COUNT-1:0] status;
    logic [EVENT_COUNT-1:0] next_status;
    logic [EVENT_COUNT-1:0] mask;
    logic [EVENT_COUNT-1:0] next_mask;
    logic next_irq;
    logic startBreak;
    logic genBaudClk;
    logic bitTick;
    logic detDone;
    logic detOk;
    logic rxReady;
    logic runBaud;
    logic wrMode;
    logic wrClksel;
    logic wrDivisor;
    logic wrControl;
    logic wrStatus;
    logic wrMask;
    logic [EVENT_COUNT-1:0] events;

    // ************************************************************
    // Bus slave
    // ************************************************************

    // Address phase capture and read data, zero wait states
    always_comb begin
        next_dataPhase.active = hsel && hready && htrans == HTRANS_NONSEQ;
        next_dataPhase.write = hwrite;
        next_dataPhase.addr = haddr[7:0];
        next_hrdata = 32'h00000000;
        if (next_dataPhase.active && !hwrite) begin
            case (haddr[7:0])
                MODE_OFFSET: begin
                    next_hrdata[POWER_POS] = mode.power;
                    next_hrdata[TX_ENABLE_POS] = mode.txEnable;
                    next_hrdata[RX_ENABLE_POS] = mode.rxEnable;
                end
                CLKSEL_OFFSET: begin
                    next_hrdata[3:0] = prescale;
                end
                DIVISOR_OFFSET: begin
                    next_hrdata[7:0] = divisor;
                end
                CONTROL_OFFSET: begin
                    // Trigger bit is write-only and reads zero
                    next_hrdata[FAIL_FLAG_POS] = failFlag;
                end
                STATUS_OFFSET: begin
                    next_hrdata[EVENT_COUNT-1:0] = status;
                end
                MASK_OFFSET: begin
                    next_hrdata[EVENT_COUNT-1:0] = mask;
                end
                default: begin
                    next_hrdata = 32'h00000000;
                end
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk) begin
        if (rst) begin
            dataPhase <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dataPhase <= next_dataPhase;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write strobes, taken in the data phase
    assign wrMode = dataPhase.active && dataPhase.write &&
        dataPhase.addr == MODE_OFFSET;
    assign wrClksel = dataPhase.active && dataPhase.write &&
        dataPhase.addr == CLKSEL_OFFSET;
    assign wrDivisor = dataPhase.active && dataPhase.write &&
        dataPhase.addr == DIVISOR_OFFSET;
    assign wrControl = dataPhase.active && dataPhase.write &&
        dataPhase.addr == CONTROL_OFFSET;
    assign wrStatus = dataPhase.active && dataPhase.write &&
        dataPhase.addr == STATUS_OFFSET;
    assign wrMask = dataPhase.active && dataPhase.write &&
        dataPhase.addr == MASK_OFFSET;

    // ************************************************************
    // Configuration
    // ************************************************************

    // Mode, prescale and divisor; software keeps the write order safe
    always_comb begin
        next_mode = mode;
        next_prescale = prescale;
        next_divisor = divisor;
        next_mask = mask;
        if (wrMode) begin
            next_mode.power = hwdata[POWER_POS];
            next_mode.txEnable = hwdata[TX_ENABLE_POS];
            next_mode.rxEnable = hwdata[RX_ENABLE_POS];
        end
        if (wrClksel) begin
            next_prescale = hwdata[3:0];
        end
        if (wrDivisor) begin
            next_divisor = hwdata[7:0];
        end
        if (wrMask) begin
            next_mask = hwdata[EVENT_COUNT-1:0];
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= '0;
            prescale <= PRESCALE_RESET;
            divisor <= DIVISOR_RESET;
            mask <= '0;
        end else begin
            mode <= next_mode;
            prescale <= next_prescale;
            divisor <= next_divisor;
            mask <= next_mask;
        end
    end

    assign runBaud = mode.power && (mode.txEnable || mode.rxEnable);
    assign rxReady = mode.power && mode.rxEnable;

    // ************************************************************
    // Baud generation and break detection
    // ************************************************************

    // Divider chain with halving stage
    uart_baud_gen baudGen (
        .clk(clk),
        .rst(rst),
        .run(runBaud),
        .prescale(prescale),
        .divisor(divisor),
        .baudClk(genBaudClk),
        .bitTick(bitTick)
    );

    // Any control write with trigger set restarts while receive is ready, same value or not
    assign startBreak = wrControl && hwdata[TRIGGER_POS] && rxReady;

    // Low-period detector on the receive line
    uart_break_detect breakDetect (
        .clk(clk),
        .rst(rst),
        .start(startBreak),
        .enable(rxReady),
        .bitTick(bitTick),
        .rxd(rxd),
        .done(detDone),
        .ok(detOk)
    );

    // ************************************************************
    // Trigger, failure flag and interrupt
    // ************************************************************

    // Trigger self-clears on completion; failure flag holds until a success
    always_comb begin
        next_breakActive = breakActive;
        next_failFlag = failFlag;
        if (startBreak) begin
            next_breakActive = 1'b1;
        end else if (detDone || !rxReady) begin
            next_breakActive = 1'b0;
        end
        if (detDone && !detOk) begin
            next_failFlag = 1'b1;
        end else if (detDone && detOk) begin
            next_failFlag = 1'b0;
        end
        events = '0;
        events[EV_DONE] = detDone && detOk;
        events[EV_FAIL] = detDone && !detOk;
        // Set wins over a write-one clear in the same cycle
        next_status = status & ~(wrStatus ? hwdata[EVENT_COUNT-1:0] : '0);
        next_status = next_status | events;
        next_irq = |(next_status & next_mask);
    end

    // Control flags, status and output registers
    always_ff @(posedge clk) begin
        if (rst) begin
            breakActive <= 1'b0;
            failFlag <= 1'b0;
            status <= '0;
            irq <= 1'b0;
            baudClk <= 1'b0;
        end else begin
            breakActive <= next_breakActive;
            failFlag <= next_failFlag;
            status <= next_status;
            irq <= next_irq;
            baudClk <= genBaudClk;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_breakEnds;
        detDone && !startBreak;
    endsequence

    sequence s_triggerWrite;
        wrControl && hwdata[TRIGGER_POS] && rxReady;
    endsequence

    a_trigger_clear: assert property (@(posedge clk) disable iff (rst)
        s_breakEnds |=> !breakActive)
        else $error("trigger stayed set after completion");

    a_refresh_start: assert property (@(posedge clk) disable iff (rst)
        s_triggerWrite |=> breakActive ##1 (breakActive || detDone))
        else $error("control refresh did not start a break reception");

    a_fail_hold: assert property (@(posedge clk) disable iff (rst)
        (failFlag && !(detDone && detOk)) |=> failFlag)
        else $error("failure flag dropped without a success");

    a_fail_set: assert property (@(posedge clk) disable iff (rst)
        (detDone && !detOk) |=> failFlag && status[EV_FAIL])
        else $error("failed break did not set the flag");

    a_trigger_reads: assert property (@(posedge clk) disable iff (rst)
        (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite &&
        haddr[7:0] == CONTROL_OFFSET) |=> hrdata[31:1] == 31'h0)
        else $error("trigger bit read back as one");

    a_success_clears: assert property (@(posedge clk) disable iff (rst)
        s_breakEnds and (detOk) |=> !breakActive && !failFlag)
        else $error("correct break left trigger or flag set");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(status & mask))
        else $error("interrupt does not follow masked status");

endmodule : uart_baud_and_break_control

/* lin_node_model.sv */
// Remote LIN node model that sends sync-break fields on the receive line
`timescale 1ns/1ns
module lin_node_model (
    input wire logic clk,
    input wire logic baudClk,
    output logic rxd
);
    logic baudPrev;

    // ************************************************************
    // Bit timing taken from the block's baud clock
    // ************************************************************

    // Remember the baud clock to spot its rising edges
    always @(posedge clk) begin
        baudPrev <= baudClk;
    end

    // Line idles high through its pull-up
    initial begin
        rxd = 1'b1;
        baudPrev = 1'b0;
    end

    // Pull the line low for a whole number of bit times, then let it go high
    task automatic send_break(input int bits);
        int n;
        n = 0;
        @(posedge clk);
        while (!(baudClk === 1'b1 && baudPrev === 1'b0)) @(posedge clk);
        rxd <= 1'b0;
        while (n < bits) begin
            @(posedge clk);
            if (baudClk === 1'b1 && baudPrev === 1'b0) n++;
        end
        rxd <= 1'b1;
    endtask : send_break
endmodule : lin_node_model

/* uart_baud_and_break_control_bench.sv */
// Self-checking bench for baud generation and break reception control
`timescale 1ns/1ns
module uart_baud_and_break_control_bench import uart_break_pkg::*;;
    localparam int LIMIT = 30000;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rxd, baudClk, breakActive, irq, baudPrev;
    logic [15:0] rnd;
    int n_mismatch, checks, cycles;
    int expMode, expPre, expDiv, expStat, expMask, expFail;

    // ************************************************************
    // Design, far-side node and clock
    // ************************************************************
    assign hready = hreadyout;

    uart_baud_and_break_control i_dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .baudClk(baudClk),
        .breakActive(breakActive), .irq(irq));

    lin_node_model i_node (.clk(clk), .baudClk(baudClk), .rxd(rxd));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Baud edge tracking and hang guard
    always @(posedge clk) begin
        baudPrev <= baudClk;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Reference model and comparison
    // ************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [31:0] model_read(input logic [7:0] a);
        case (a)
            MODE_OFFSET: return expMode;
            CLKSEL_OFFSET: return expPre;
            DIVISOR_OFFSET: return expDiv;
            CONTROL_OFFSET: return expFail;
            STATUS_OFFSET: return expStat;
            MASK_OFFSET: return expMask;
            default: return 32'h0;
        endcase
    endfunction : model_read

    task automatic model_write(input logic [7:0] a, input logic [31:0] d);
        case (a)
            MODE_OFFSET: expMode = d & 32'he0;
            CLKSEL_OFFSET: expPre = d & 32'hf;
            DIVISOR_OFFSET: expDiv = d & 32'hff;
            STATUS_OFFSET: expStat = expStat & ~(d & 32'h3);
            MASK_OFFSET: expMask = d & 32'h3;
            default: ;
        endcase
    endtask : model_write

    task automatic compare(input string what, input logic [31:0] got,
                           input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got,
                     exp);
        end
    endtask : compare

    // ************************************************************
    // AHB-Lite master
    // ************************************************************
    task automatic wait_ready();
        do @(posedge clk); while (hready !== 1'b1);
    endtask : wait_ready

    // Address phase held until accepted, then bus goes idle
    task automatic addr_phase(input logic [7:0] a, input logic w);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : addr_phase

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        wait_ready();
        model_write(a, d);
    endtask : bus_write

    // Read data and response taken at the edge that ends the data phase
    task automatic reg_check(input logic [7:0] a);
        addr_phase(a, 1'b0);
        wait_ready();
        compare("read data", hrdata, model_read(a));
        compare("response", {31'h0, hresp}, 32'h0);
    endtask : reg_check

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic check_irq();
        repeat (2) @(posedge clk);
        compare("interrupt", {31'h0, irq}, {31'h0, (expStat & expMask) != 0});
    endtask : check_irq

    // Wait for a rising baud edge and report the clocks spent
    task automatic wait_rise(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(baudClk === 1'b1 && baudPrev === 1'b0) && n < 4000);
    endtask : wait_rise

    task automatic test_baud(input int p, input int d);
        int t;
        int e;
        bus_write(MODE_OFFSET, 32'h0);
        bus_write(CLKSEL_OFFSET, p);
        bus_write(DIVISOR_OFFSET, d);
        reg_check(CLKSEL_OFFSET);
        reg_check(DIVISOR_OFFSET);
        bus_write(MODE_OFFSET, 32'h80);
        bus_write(MODE_OFFSET, 32'hc0);
        wait_rise(t);
        wait_rise(t);
        // Divisor zero counts as one, prescale above the ceiling clamps
        e = (d == 0) ? 1 : d;
        e = e * (2 << ((p > PRESCALE_MAX) ? PRESCALE_MAX : p));
        compare("baud period", t, e);
        $display("test baud done");
    endtask : test_baud

    // Trigger a break reception and have the node send a low field
    task automatic run_break(input int bits);
        int n;
        n = 0;
        bus_write(CONTROL_OFFSET, 32'h40);
        @(posedge clk);
        compare("trigger state", {31'h0, breakActive}, 32'h1);
        reg_check(CONTROL_OFFSET);
        i_node.send_break(bits);
        while (breakActive === 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        compare("trigger clear", {31'h0, breakActive}, 32'h0);
        expStat = expStat | ((bits >= 11) ? 1 : 2);
        expFail = (bits >= 11) ? 0 : 1;
        check_irq();
        reg_check(STATUS_OFFSET);
        reg_check(CONTROL_OFFSET);
        $display("test break of %0d bits done", bits);
    endtask : run_break

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        rst = 1'b1;
        rnd = 16'hfe74;
        {n_mismatch, checks, cycles, expMode, expPre} = '0;
        {expStat, expMask, expFail} = '0;
        expDiv = 32'hff;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 8'h18; a += 4) reg_check(8'(a));
        rnd = lfsr_next(rnd);
        bus_write(8'h18, {rnd, rnd});
        reg_check(8'h18);
        $display("test reset and map done");
        test_baud(11, 1);
        test_baud(1, 0);
        rnd = lfsr_next(rnd);
        test_baud(rnd % 3, 2 + rnd[7:0] % 4);
        bus_write(MODE_OFFSET, 32'h80);
        bus_write(MODE_OFFSET, 32'ha0);
        bus_write(MASK_OFFSET, 32'h2);
        run_break(13);
        bus_write(MASK_OFFSET, 32'h3);
        check_irq();
        bus_write(STATUS_OFFSET, 32'h1);
        check_irq();
        run_break(8);
        bus_write(STATUS_OFFSET, 32'h3);
        check_irq();
        reg_check(CONTROL_OFFSET);
        run_break(9);
        bus_write(STATUS_OFFSET, 32'h2);
        run_break(12);
        bus_write(MODE_OFFSET, 32'hc0);
        bus_write(CONTROL_OFFSET, 32'h40);
        @(posedge clk);
        compare("ignored trigger", {31'h0, breakActive}, 32'h0);
        reg_check(STATUS_OFFSET);
        $display("test trigger without receive done");
        tally_and_finish();
    end
endmodule : uart_baud_and_break_control_bench
